/* hw/i2csh_top.sv */
// I2C client clock stretching, address match and host start/stop control
// Functional notes
// - 10-bit hold reception matches 7-bit behaviour besides address rewrite on update
// - With hold bit clear, drive SCL low only after sampling it low
// - Setting hold bit releases SCL; others may still hold it low
// - After acknowledged read request clear hold bit and stretch until hold bit set again
// - Stretch enable holds SCL low after every acknowledge sequence
// - Buffer-full flag never affects stretching decisions
// - Address update flag holds SCL without clearing hold bit; write releases
// - Address hold clears hold bit after eighth fall of matching address
// - Data hold clears hold bit after eighth fall of each received (write) data byte
// - SCL stays low until hold bit set and bus released
// - General call enable acknowledges address zero write, raising interrupt flag
// - General call in 10-bit mode skips address update; next byte data
// - Address hold also stretches after general call address byte
// - Zero mask bits make received address bits don't-care
// - Address mask resets to all ones
// - Mask covers A[7:1] in 7-bit, low byte in 10-bit, never high byte
// - Start and stop flags clear on reset and when port disabled
// - Firmware host mode keeps only start/stop detection active
// - Host mode interrupt on detected start or stop and on completion of own start/stop generation
// - Buffer write before start completes is dropped, setting collision flag
// - Own start/stop generation suspends detection; interrupt when bit clears
`timescale 1ns/10ps
`include "i2csh_consts.svh"
module i2c_client_stretch_host_ctrl
  import i2csh_pkg::*;
#(
  parameter int BRG_W = 8
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sclOut,
  output logic sclOe_n,
  output logic sdaOut,
  output logic sdaOe_n,
  input wire logic port_enable,
  input wire logic hostMode,
  input wire logic firmwareHost,
  input wire logic tenBitMode,
  input wire logic stretch_or_start_enable,
  input wire logic stopGenReq,
  input wire logic address_hold_enable,
  input wire logic data_hold_enable,
  input wire logic general_call_enable,
  input wire logic ackValue,
  input wire logic holdReleaseSet,
  input wire logic addrWrite,
  input wire logic [7:0] addrWriteData,
  input wire logic maskWrite,
  input wire logic [7:0] maskWriteData,
  input wire logic bufWrite,
  input wire logic [7:0] bufWriteData,
  input wire logic bufRead,
  input wire logic intClear,
  input wire logic wcolClear,
  input wire logic [BRG_W-1:0] baudReload,
  output logic clock_hold_release,
  output logic address_update_needed,
  output logic buffer_full_flag,
  output logic port_interrupt_flag,
  output logic write_collision_flag,
  output logic startFlag,
  output logic stopFlag,
  output logic readMode,
  output logic stretch_active,
  output logic [7:0] transfer_buffer,
  output logic [7:0] address_register,
  output logic [7:0] address_mask_register
);
  i2csh_line_if lines ();
  i2csh_state_e state_reg;
  i2csh_gen_e gen_reg;
  logic [7:0] shift_register;
  logic [7:0] txShift_reg;
  logic [3:0] bitCnt_reg;
  logic ackDrive_reg;
  logic sclHold_reg;
  logic sdaDrive_reg;
  logic genScl_reg;
  logic genPhase_reg;
  logic addressed_reg;
  logic isGcall_reg;
  logic byteMatch;
  logic hostBusy;
  logic baudTick;
  logic genRun;

  i2csh_line_sync u_sync (
    .mclk(mclk),
    .rst_n(rst_n),
    .sclIn(sclIn),
    .sdaIn(sdaIn),
    .lines(lines.src)
  );

  i2csh_baud_gen #(.WIDTH(BRG_W)) u_baud (
    .mclk(mclk),
    .rst_n(rst_n),
    .run(genRun),
    .sclReleased(!genScl_reg),
    .sclLevel(lines.sclLevel),
    .reload(baudReload),
    .tick(baudTick)
  );

  // ==========================================
  // Address compare: mask applies only to masked fields
  function automatic logic addrMatch(input logic [7:0] rx, input logic [7:0] own, input logic [7:0] msk);
    addrMatch = ((rx ^ own) & msk) == 8'h00;
  endfunction

  always_comb begin
    byteMatch = 1'b0;
    if (state_reg == I2CSH_ADDR) begin
      if (general_call_enable && shift_register == `I2CSH_GCALL_ADDR) begin
        byteMatch = 1'b1;
      end else if (tenBitMode) begin
        byteMatch = shift_register[7:1] == address_register[7:1];
      end else begin
        byteMatch = addrMatch({shift_register[7:1], 1'b0}, {address_register[7:1], 1'b0},
          {address_mask_register[7:1], 1'b0});
      end
    end else if (state_reg == I2CSH_ADDR2) begin
      byteMatch = addrMatch(shift_register, address_register, address_mask_register);
    end
  end

  assign genRun = hostMode && !firmwareHost && gen_reg != I2CSH_GEN_NONE;
  assign hostBusy = gen_reg != I2CSH_GEN_NONE;

  // ==========================================
  // Mask and address registers
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      address_mask_register <= `I2CSH_MASK_RESET;
    end else if (maskWrite) begin
      address_mask_register <= maskWriteData;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      address_register <= `I2CSH_ADDR_RESET;
    end else if (addrWrite) begin
      address_register <= addrWriteData;
    end
  end

  // ==========================================
  // Client byte engine
  always_ff @(posedge mclk) begin
    if (!rst_n || !port_enable || hostMode) begin
      state_reg <= I2CSH_IDLE;
      shift_register <= 8'h00;
      bitCnt_reg <= 4'h0;
      ackDrive_reg <= 1'b0;
      addressed_reg <= 1'b0;
      isGcall_reg <= 1'b0;
      readMode <= 1'b0;
    end else if (lines.startSeen) begin
      state_reg <= I2CSH_ADDR;
      // Start's own SCL fall wraps this to zero, so it is not counted as a bit
      bitCnt_reg <= 4'hF;
      ackDrive_reg <= 1'b0;
      addressed_reg <= 1'b0;
      isGcall_reg <= 1'b0;
    end else if (lines.stopSeen) begin
      state_reg <= I2CSH_IDLE;
      ackDrive_reg <= 1'b0;
    end else begin
      if (lines.sclRise && bitCnt_reg < `I2CSH_BITS_PER_BYTE) begin
        shift_register <= {shift_register[6:0], lines.sdaLevel};
      end
      if (lines.sclRise && bitCnt_reg == `I2CSH_BITS_PER_BYTE && readMode && state_reg == I2CSH_DATA
          && lines.sdaLevel) begin
        state_reg <= I2CSH_SKIP;
      end
      if (lines.sclFall) begin
        if (bitCnt_reg == `I2CSH_BITS_PER_BYTE - 4'h1) begin
          bitCnt_reg <= `I2CSH_BITS_PER_BYTE;
          if (byteMatch || state_reg == I2CSH_DATA) begin
            ackDrive_reg <= !readMode || state_reg != I2CSH_DATA;
            if (state_reg == I2CSH_ADDR) begin
              isGcall_reg <= general_call_enable && shift_register == `I2CSH_GCALL_ADDR;
              readMode <= shift_register[0];
            end
          end
        end else if (bitCnt_reg == `I2CSH_BITS_PER_BYTE) begin
          bitCnt_reg <= 4'h0;
          ackDrive_reg <= 1'b0;
          case (state_reg)
            I2CSH_ADDR: begin
              if (!byteMatch) begin
                state_reg <= I2CSH_SKIP;
              end else if (tenBitMode && !isGcall_reg && !readMode) begin
                state_reg <= I2CSH_ADDR2;
              end else begin
                state_reg <= I2CSH_DATA;
                addressed_reg <= 1'b1;
              end
            end
            I2CSH_ADDR2: begin
              state_reg <= byteMatch ? I2CSH_DATA : I2CSH_SKIP;
              addressed_reg <= byteMatch;
            end
            I2CSH_DATA: state_reg <= I2CSH_DATA;
            I2CSH_ACK: state_reg <= I2CSH_DATA;
            I2CSH_SKIP: state_reg <= I2CSH_SKIP;
            default: state_reg <= I2CSH_IDLE;
          endcase
        end else if (state_reg != I2CSH_IDLE && state_reg != I2CSH_SKIP) begin
          bitCnt_reg <= bitCnt_reg + 4'h1;
        end
      end
    end
  end

  // ==========================================
  // Hold bit: hardware clears, software sets; a hardware clear wins
  always_ff @(posedge mclk) begin
    if (!rst_n || !port_enable) begin
      clock_hold_release <= 1'b1;
    end else if (lines.sclFall && !hostMode) begin
      if (bitCnt_reg == `I2CSH_BITS_PER_BYTE - 4'h1 && byteMatch && address_hold_enable) begin
        clock_hold_release <= 1'b0;
      end else if (bitCnt_reg == `I2CSH_BITS_PER_BYTE - 4'h1 && state_reg == I2CSH_DATA && !readMode
          && data_hold_enable) begin
        clock_hold_release <= 1'b0;
      end else if (bitCnt_reg == `I2CSH_BITS_PER_BYTE && (byteMatch || state_reg == I2CSH_DATA)
          && (readMode || stretch_or_start_enable)) begin
        // Independent of buffer_full_flag on purpose: legacy skipping caused races
        clock_hold_release <= 1'b0;
      end else if (holdReleaseSet) begin
        clock_hold_release <= 1'b1;
      end
    end else if (holdReleaseSet) begin
      clock_hold_release <= 1'b1;
    end
  end

  // ==========================================
  // Address update flag for 10-bit client reception
  always_ff @(posedge mclk) begin
    if (!rst_n || !port_enable || hostMode || !tenBitMode) begin
      address_update_needed <= 1'b0;
    end else if (lines.sclFall && bitCnt_reg == `I2CSH_BITS_PER_BYTE && !isGcall_reg && !readMode
        && (state_reg == I2CSH_ADDR2 || (state_reg == I2CSH_ADDR && byteMatch))) begin
      address_update_needed <= 1'b1;
    end else if (addrWrite) begin
      address_update_needed <= 1'b0;
    end
  end

  // ==========================================
  // SCL hold: only extends a low phase already seen on the bus
  always_ff @(posedge mclk) begin
    if (!rst_n || !port_enable || hostMode) begin
      sclHold_reg <= 1'b0;
    end else if (clock_hold_release && !address_update_needed) begin
      sclHold_reg <= 1'b0;
    end else if (address_update_needed && addrWrite) begin
      sclHold_reg <= 1'b0;
    end else if (!lines.sclLevel) begin
      sclHold_reg <= 1'b1;
    end
  end
  assign stretch_active = sclHold_reg;

  // ==========================================
  // Buffer, transmit shifter, collision flag
  always_ff @(posedge mclk) begin
    if (!rst_n || !port_enable) begin
      transfer_buffer <= 8'h00;
      buffer_full_flag <= 1'b0;
      txShift_reg <= 8'hFF;
    end else if (bufWrite && !(hostMode && hostBusy)) begin
      transfer_buffer <= bufWriteData;
      txShift_reg <= bufWriteData;
      buffer_full_flag <= 1'b1;
    end else if (lines.sclFall && bitCnt_reg == `I2CSH_BITS_PER_BYTE - 4'h1 && !readMode
        && (byteMatch || state_reg == I2CSH_DATA)) begin
      transfer_buffer <= shift_register;
      buffer_full_flag <= 1'b1;
    end else begin
      if (bufRead) begin
        buffer_full_flag <= 1'b0;
      end
      if (lines.sclFall && readMode && state_reg == I2CSH_DATA && bitCnt_reg < `I2CSH_BITS_PER_BYTE) begin
        txShift_reg <= {txShift_reg[6:0], 1'b1};
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n || !port_enable) begin
      write_collision_flag <= 1'b0;
    end else if (bufWrite && hostMode && hostBusy) begin
      write_collision_flag <= 1'b1;
    end else if (wcolClear) begin
      write_collision_flag <= 1'b0;
    end
  end

  // ==========================================
  // Host start/stop generation paced by the baud generator
  always_ff @(posedge mclk) begin
    if (!rst_n || !port_enable || !hostMode || firmwareHost) begin
      gen_reg <= I2CSH_GEN_NONE;
      genPhase_reg <= 1'b0;
      sdaDrive_reg <= 1'b0;
      genScl_reg <= 1'b0;
    end else begin
      case (gen_reg)
        I2CSH_GEN_NONE: begin
          genPhase_reg <= 1'b0;
          if (stretch_or_start_enable && lines.sclLevel && lines.sdaLevel) begin
            gen_reg <= I2CSH_GEN_START;
          end else if (stopGenReq) begin
            gen_reg <= I2CSH_GEN_STOP;
            sdaDrive_reg <= 1'b1;
          end
        end
        I2CSH_GEN_START: begin
          if (baudTick) begin
            sdaDrive_reg <= 1'b1;
            genPhase_reg <= 1'b1;
            if (genPhase_reg) begin
              gen_reg <= I2CSH_GEN_NONE;
              genScl_reg <= 1'b1;
            end
          end
        end
        I2CSH_GEN_STOP: begin
          genScl_reg <= 1'b0;
          if (baudTick) begin
            genPhase_reg <= 1'b1;
            if (genPhase_reg) begin
              sdaDrive_reg <= 1'b0;
              gen_reg <= I2CSH_GEN_NONE;
            end
          end
        end
        default: gen_reg <= I2CSH_GEN_NONE;
      endcase
    end
  end

  // ==========================================
  // Start/stop flags, suspended during own generation
  always_ff @(posedge mclk) begin
    if (!rst_n || !port_enable) begin
      startFlag <= 1'b0;
      stopFlag <= 1'b0;
    end else if (!hostBusy) begin
      if (lines.startSeen) begin
        startFlag <= 1'b1;
        stopFlag <= 1'b0;
      end else if (lines.stopSeen) begin
        stopFlag <= 1'b1;
        startFlag <= 1'b0;
      end
    end
  end

  // ==========================================
  // Interrupt flag; a new event wins over a clear in the same cycle
  always_ff @(posedge mclk) begin
    if (!rst_n || !port_enable) begin
      port_interrupt_flag <= 1'b0;
    end else if ((hostMode && !hostBusy && (lines.startSeen || lines.stopSeen))
        || (hostBusy && baudTick && genPhase_reg)
        || (lines.sclFall && bitCnt_reg == `I2CSH_BITS_PER_BYTE && (hostMode || byteMatch
        || address_update_needed || state_reg == I2CSH_DATA || state_reg == I2CSH_ADDR2))
        || (!hostMode && lines.sclFall && bitCnt_reg == `I2CSH_BITS_PER_BYTE - 4'h1 && byteMatch
        && address_hold_enable)) begin
      port_interrupt_flag <= 1'b1;
    end else if (intClear) begin
      port_interrupt_flag <= 1'b0;
    end
  end

  // ==========================================
  // Pin drivers; enable low means driving low
  always_comb begin
    sclOut = 1'b0;
    sdaOut = 1'b0;
    sclOe_n = !(sclHold_reg || genScl_reg);
    sdaOe_n = 1'b1;
    if (sdaDrive_reg) begin
      sdaOe_n = 1'b0;
    end else if (ackDrive_reg) begin
      sdaOe_n = ackValue;
    end else if (!hostMode && readMode && state_reg == I2CSH_DATA && addressed_reg) begin
      sdaOe_n = txShift_reg[7];
    end
  end
endmodule

/* hw/i2csh_consts.svh */
// Constants of the I2C client-stretch and host-control block
`ifndef I2CSH_CONSTS_SVH
`define I2CSH_CONSTS_SVH
`define I2CSH_MASK_RESET 8'hFF
`define I2CSH_GCALL_ADDR 8'h00
`define I2CSH_ADDR_RESET 8'h00
`define I2CSH_BRG_RESET 8'h04
`define I2CSH_HI10_PREFIX 5'h1E
`define I2CSH_CLK_MHZ 50
`define I2CSH_BITS_PER_BYTE 4'h8
`define I2CSH_ACK_BIT 4'h9
`endif

/* hw/i2csh_pkg.sv */
// Types shared by the I2C client-stretch and host-control block
package i2csh_pkg;
  typedef enum logic [2:0] {
    I2CSH_IDLE = 3'b000,
    I2CSH_ADDR = 3'b001,
    I2CSH_ADDR2 = 3'b011,
    I2CSH_DATA = 3'b010,
    I2CSH_ACK = 3'b110,
    I2CSH_SKIP = 3'b111
  } i2csh_state_e;
  typedef enum logic [1:0] {
    I2CSH_GEN_NONE = 2'b00,
    I2CSH_GEN_START = 2'b01,
    I2CSH_GEN_STOP = 2'b11
  } i2csh_gen_e;
endpackage

/* hw/i2csh_line_if.sv */
// Synchronised bus line levels and their edges
`timescale 1ns/10ps
interface i2csh_line_if;
  logic sclLevel;
  logic sdaLevel;
  logic sclRise;
  logic sclFall;
  logic startSeen;
  logic stopSeen;
  modport src (output sclLevel, sdaLevel, sclRise, sclFall, startSeen, stopSeen);
  modport dst (input sclLevel, sdaLevel, sclRise, sclFall, startSeen, stopSeen);
endinterface

/* hw/i2csh_line_sync.sv */
// Two-flop synchronisers and edge/condition detection for SCL and SDA
`timescale 1ns/10ps
module i2csh_line_sync (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic sclIn,
  input wire logic sdaIn,
  i2csh_line_if.src lines
);
  logic [1:0] sclSync_reg;
  logic [1:0] sdaSync_reg;
  logic sclOld_reg;
  logic sdaOld_reg;
  // ==========================================
  // Synchronisers
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      sclSync_reg <= 2'h3;
      sdaSync_reg <= 2'h3;
    end else begin
      sclSync_reg <= {sclSync_reg[0], sclIn};
      sdaSync_reg <= {sdaSync_reg[0], sdaIn};
    end
  end
  // ==========================================
  // Edge history, read only from the second stage
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      sclOld_reg <= 1'b1;
      sdaOld_reg <= 1'b1;
    end else begin
      sclOld_reg <= sclSync_reg[1];
      sdaOld_reg <= sdaSync_reg[1];
    end
  end
  assign lines.sclLevel = sclSync_reg[1];
  assign lines.sdaLevel = sdaSync_reg[1];
  assign lines.sclRise = sclSync_reg[1] & ~sclOld_reg;
  assign lines.sclFall = ~sclSync_reg[1] & sclOld_reg;
  assign lines.startSeen = sclSync_reg[1] & sclOld_reg & sdaOld_reg & ~sdaSync_reg[1];
  assign lines.stopSeen = sclSync_reg[1] & sclOld_reg & ~sdaOld_reg & sdaSync_reg[1];
endmodule

/* hw/i2csh_baud_gen.sv */
// Baud generator with clock arbitration on the sampled SCL level
`timescale 1ns/10ps
module i2csh_baud_gen #(
  parameter int WIDTH = 8
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic run,
  input wire logic sclReleased,
  input wire logic sclLevel,
  input wire logic [WIDTH-1:0] reload,
  output logic tick
);
  logic [WIDTH-1:0] count_reg;
  logic waitHigh_reg;
  // ==========================================
  // Counter; stalls while a released SCL is still held low outside
  always_ff @(posedge mclk) begin
    if (!rst_n || !run) begin
      count_reg <= reload;
      waitHigh_reg <= 1'b0;
    end else if (sclReleased && !sclLevel) begin
      count_reg <= reload;
      waitHigh_reg <= 1'b1;
    end else if (waitHigh_reg || count_reg == '0) begin
      count_reg <= reload;
      waitHigh_reg <= 1'b0;
    end else begin
      count_reg <= count_reg - 1'b1;
    end
  end
  assign tick = run && !waitHigh_reg && !(sclReleased && !sclLevel) && count_reg == '0;
endmodule

/* verification/i2csh_top_props.sv */
// Port-level checker for the client stretch and host control block
`timescale 1ns/10ps
module i2csh_checker (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic sclIn,
  input wire logic sclOe_n,
  input wire logic port_enable,
  input wire logic hostMode,
  input wire logic addrWrite,
  input wire logic bufWrite,
  input wire logic clock_hold_release,
  input wire logic address_update_needed,
  input wire logic write_collision_flag,
  input wire logic startFlag,
  input wire logic stopFlag
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  // ==========================================================
  // Reset, disable and collision
  AST_RESET_FLAGS: assert property ($rose(rst_n) |-> !startFlag && !stopFlag && clock_hold_release)
    else $error("flags or hold bit wrong after reset");
  AST_DISABLE_CLEARS: assert property (!port_enable ##1 !port_enable |-> !startFlag && !stopFlag)
    else $error("condition flags kept while disabled");
  AST_WRITE_COLLISION_FLAG_CAUSE: assert property ($rose(write_collision_flag) |-> $past(bufWrite))
    else $error("collision flag without buffer write");
  // ==========================================================
  // Client clock stretching
  AST_HOLD_AFTER_LOW: assert property (!hostMode && $fell(sclOe_n) |-> !$past(sclIn) && !$past(sclIn, 2))
    else $error("SCL pulled low before it was seen low");
  AST_RELEASE_WITH_HOLD: assert property (port_enable && !hostMode && $rose(sclOe_n) |-> clock_hold_release)
    else $error("SCL released with hold bit clear");
  AST_STRETCH_WHEN_CLEAR: assert property ((port_enable && !hostMode && !clock_hold_release && !sclIn) [*4]
    |-> !sclOe_n)
    else $error("SCL not held with hold bit clear");
  AST_UPDATE_HOLDS: assert property ((address_update_needed && !addrWrite && !sclIn && !hostMode) [*4]
    |-> !sclOe_n)
    else $error("SCL not held while address update pending");
  AST_UPDATE_RELEASE: assert property (address_update_needed && addrWrite && clock_hold_release && !hostMode
    |=> sclOe_n)
    else $error("SCL not released after address write");
endmodule

/* verification/i2csh_host_model.sv */
// Bus host model: open-drain SCL and SDA, 160 ns bit time, waits out stretching
`timescale 1ns/10ps
module i2csh_host_model (
  input wire logic mclk,
  input wire logic sclWire,
  input wire logic sdaWire,
  output logic sclDrv,
  output logic sdaDrv,
  output logic stuck
);
  initial begin
    sclDrv <= 1'b1;
    sdaDrv <= 1'b1;
    stuck <= 1'b0;
  end
  task automatic half();
    repeat (3) @(posedge mclk);
  endtask
  // Bounded, so a client that never lets go cannot hang the run
  task automatic waitHigh(input logic needSda);
    int n;
    n = 0;
    @(posedge mclk);
    while ((!sclWire || (needSda && !sdaWire)) && n < 3000) begin
      @(posedge mclk);
      n++;
    end
    if (n == 3000) begin
      stuck <= 1'b1;
    end
  endtask
  task automatic start();
    waitHigh(1'b1);
    sdaDrv <= 1'b0;
    half();
    sclDrv <= 1'b0;
    half();
  endtask
  task automatic stop();
    @(posedge mclk);
    sdaDrv <= 1'b0;
    half();
    sclDrv <= 1'b1;
    waitHigh(1'b0);
    half();
    sdaDrv <= 1'b1;
    half();
  endtask
  task automatic clk(output logic bitVal);
    half();
    sclDrv <= 1'b1;
    waitHigh(1'b0);
    half();
    bitVal = sdaWire;
    sclDrv <= 1'b0;
    @(posedge mclk);
  endtask
  // Ninth bit always released: reads are single bytes ended by a not-ack
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx, output logic ack);
    @(posedge mclk);
    for (int i = 7; i >= 0; i--) begin
      sdaDrv <= tx[i];
      clk(rx[i]);
    end
    sdaDrv <= 1'b1;
    clk(ack);
  endtask
endmodule

/* verification/tb.sv */
// Self-checking bench for the client stretch and host control block
`timescale 1ns/10ps
module tb;
  localparam int HOLD = 6, ICLR = 5, WCLR = 4, WADDR = 2, WMASK = 1, WBUF = 0;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic port_enable = 1'b1, hostMode = 1'b0, tenBitMode = 1'b0, stretch_or_start_enable = 1'b0;
  logic address_hold_enable = 1'b0, general_call_enable = 1'b0, ackValue = 1'b0, bufRead = 1'b0;
  logic holdReleaseSet = 1'b0, addrWrite = 1'b0, maskWrite = 1'b0, bufWrite = 1'b0, intClear = 1'b0, wcolClear = 1'b0;
  logic data_hold_enable = 1'b0;
  logic [7:0] wData = 8'h00;
  logic sclIn, sdaIn, sclOe_n, sdaOe_n, sclDrv, sdaDrv, stuck, ack;
  logic clock_hold_release, address_update_needed, port_interrupt_flag, write_collision_flag, startFlag, stopFlag;
  logic [7:0] address_mask_register, rx;
  int error_cnt = 0;
  int comparisons = 0;
  // Pull-ups on both lines: any driver low wins
  assign sclIn = sclDrv & sclOe_n;
  assign sdaIn = sdaDrv & sdaOe_n;
  always #10 mclk = ~mclk;
  i2c_client_stretch_host_ctrl #(.BRG_W(8)) i2c_client_stretch_host_ctrl_inst (.mclk, .rst_n, .sclIn, .sdaIn,
    .sclOut(), .sclOe_n, .sdaOut(), .sdaOe_n, .port_enable, .hostMode, .firmwareHost(1'b0), .tenBitMode,
    .stretch_or_start_enable, .stopGenReq(1'b0), .address_hold_enable, .data_hold_enable,
    .general_call_enable, .ackValue, .holdReleaseSet, .addrWrite, .addrWriteData(wData), .maskWrite,
    .maskWriteData(wData), .bufWrite, .bufWriteData(wData), .bufRead, .intClear, .wcolClear, .baudReload(8'h02),
    .clock_hold_release, .address_update_needed, .buffer_full_flag(), .port_interrupt_flag, .write_collision_flag,
    .startFlag, .stopFlag, .readMode(), .stretch_active(), .transfer_buffer(), .address_register(),
    .address_mask_register);
  i2csh_host_model i2csh_host_model_inst (.mclk, .sclWire(sclIn), .sdaWire(sdaIn), .sclDrv, .sdaDrv, .stuck);
  // ==========================================================
  // Helpers
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("comparisons %0d errors %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic waitOe(input logic lvl);
    int n;
    n = 0;
    while (sclOe_n !== lvl && n < 400) begin
      @(negedge mclk);
      n++;
    end
    chk(8'(sclOe_n), 8'(lvl));
    if (n == 400) begin
      summarize();
    end
  endtask
  // One strobe for one cycle; the shared data bus only matters with its strobe
  task automatic pulse(input int sel, input logic [7:0] d);
    @(posedge mclk);
    {holdReleaseSet, intClear, wcolClear, bufRead, addrWrite, maskWrite, bufWrite} <= 7'(1 << sel);
    wData <= d;
    @(posedge mclk);
    {holdReleaseSet, intClear, wcolClear, bufRead, addrWrite, maskWrite, bufWrite} <= 7'h00;
  endtask
  task automatic send(input logic [7:0] b);
    i2csh_host_model_inst.xfer(b, rx, ack);
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_sen();
    pulse(WADDR, 8'hA0);
    stretch_or_start_enable <= 1'b1;
    i2csh_host_model_inst.start();
    send(8'hA0);
    chk(8'(ack), 8'h00);
    waitOe(1'b0);
    chk(8'(clock_hold_release), 8'h00);
    pulse(HOLD, 8'h00);
    data_hold_enable <= 1'b1;
    waitOe(1'b1);
    fork
      send(8'h3C);
      begin
        waitOe(1'b0);
        chk(8'(clock_hold_release), 8'h00);
        pulse(HOLD, 8'h00);
      end
    join
    data_hold_enable <= 1'b0;
    waitOe(1'b0);
    pulse(3, 8'h00);
    pulse(HOLD, 8'h00);
    i2csh_host_model_inst.stop();
    stretch_or_start_enable <= 1'b0;
  endtask
  task automatic t_read();
    i2csh_host_model_inst.start();
    send(8'hA1);
    chk(8'(ack), 8'h00);
    waitOe(1'b0);
    pulse(WBUF, 8'h96);
    pulse(HOLD, 8'h00);
    send(8'hFF);
    chk(rx, 8'h96);
    i2csh_host_model_inst.stop();
  endtask
  task automatic t_mask(input logic [7:0] b, input logic expAck);
    pulse(WMASK, 8'hF9);
    i2csh_host_model_inst.start();
    send(b);
    chk(8'(ack), 8'(expAck));
    i2csh_host_model_inst.stop();
    pulse(WMASK, 8'hFF);
  endtask
  task automatic t_gcall();
    general_call_enable <= 1'b1;
    address_hold_enable <= 1'b1;
    pulse(ICLR, 8'h00);
    i2csh_host_model_inst.start();
    fork
      send(8'h00);
      begin
        waitOe(1'b0);
        chk(8'(clock_hold_release), 8'h00);
        pulse(HOLD, 8'h00);
        pulse(ICLR, 8'h00);
      end
    join
    chk(8'(ack), 8'h00);
    repeat (4) @(posedge mclk);
    chk(8'(port_interrupt_flag), 8'h01);
    i2csh_host_model_inst.stop();
    general_call_enable <= 1'b0;
    address_hold_enable <= 1'b0;
  endtask
  task automatic t_ten();
    tenBitMode <= 1'b1;
    pulse(WADDR, 8'hF0);
    i2csh_host_model_inst.start();
    send(8'hF0);
    chk(8'(ack), 8'h00);
    waitOe(1'b0);
    chk(8'({address_update_needed, clock_hold_release}), 8'h03);
    pulse(WADDR, 8'h55);
    waitOe(1'b1);
    send(8'h55);
    chk(8'(ack), 8'h00);
    waitOe(1'b0);
    pulse(WADDR, 8'hA0);
    i2csh_host_model_inst.stop();
    tenBitMode <= 1'b0;
  endtask
  task automatic t_dis();
    chk(address_mask_register, 8'hFF);
    i2csh_host_model_inst.start();
    chk(8'(startFlag), 8'h01);
    i2csh_host_model_inst.stop();
    repeat (3) @(posedge mclk);
    chk(8'(stopFlag), 8'h01);
    port_enable <= 1'b0;
    repeat (3) @(posedge mclk);
    chk(8'({startFlag, stopFlag}), 8'h00);
    port_enable <= 1'b1;
  endtask
  // Last: the block's own start leaves the bus busy
  task automatic t_write_collision_flag();
    hostMode <= 1'b1;
    stretch_or_start_enable <= 1'b1;
    pulse(WBUF, 8'h5A);
    @(negedge mclk);
    chk(8'(write_collision_flag), 8'h01);
    pulse(WCLR, 8'h00);
    @(negedge mclk);
    chk(8'(write_collision_flag), 8'h00);
  endtask
  initial begin
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    t_dis();
    t_sen();
    t_read();
    t_mask(8'hA6, 1'b0);
    t_mask(8'hA8, 1'b1);
    t_gcall();
    t_ten();
    t_write_collision_flag();
    chk(8'(stuck), 8'h00);
    summarize();
  end
  initial begin
    repeat (90000) @(posedge mclk);
    error_cnt++;
    summarize();
  end
  always @(posedge stuck) begin
    error_cnt++;
    summarize();
  end
endmodule
bind i2c_client_stretch_host_ctrl i2csh_checker i2csh_checker_inst (.mclk, .rst_n, .sclIn, .sclOe_n, .port_enable,
  .hostMode, .addrWrite, .bufWrite, .clock_hold_release, .address_update_needed, .write_collision_flag,
  .startFlag, .stopFlag);
